// >>> sesl_map.vh
// constants for the standard event status logic: bit positions, command codes, reset values
// assumes a command decoder that issues one-cycle command strobes with an 8-bit operand
// Function
// - status byte bit 5 set while any enabled standard event bit is set
// - bit 0 sets once all overlapping operations, including the marker, finish
// - bits 1 and 6 of the event register always read zero
// - bit 2 flags empty error read, read without command, or full buffers
// - bit 3 flags self-test, calibration or other device faults
// - bit 4 flags execution errors, bit 5 flags syntax errors
// - bit 7 set after reset or power-up since the last event read
// - clear-status empties the whole event register
// - event query returns contents then clears the register
// - enable write replaces the whole previous event mask
// - service request enable loads an 8-bit mask, 0 to 255
// - service request enable query returns the mask unchanged
// - status byte query returns the byte without clearing bit 6
// - event bits stay latched until cleared
// - an event bit other than bit 7 latches only while its enable bit is set; bit 7 is set by reset whatever the mask
// - status byte bit 5 is event summary, bit 6 master summary
`ifndef SESL_MAP_VH
`define SESL_MAP_VH
`define SESL_BIT_OPC      0
`define SESL_BIT_QRY      2
`define SESL_BIT_DEV      3
`define SESL_BIT_EXE      4
`define SESL_BIT_CMD      5
`define SESL_BIT_PON      7
`define SESL_EVT_USED     8'hBD
`define SESL_EVT_RESET    8'h80
`define SESL_MASK_RESET   8'h00
`define SESL_STB_EAV      2
`define SESL_STB_QSB      3
`define SESL_STB_MAV      4
`define SESL_STB_ESB      5
`define SESL_STB_MSS      6
`define SESL_OP_NONE      3'h0
`define SESL_OP_ESE_WR    3'h1
`define SESL_OP_ESE_RD    3'h2
`define SESL_OP_ESR_RD    3'h3
`define SESL_OP_SRE_WR    3'h4
`define SESL_OP_SRE_RD    3'h5
`define SESL_OP_STB_RD    3'h6
`define SESL_OP_CLS       3'h7
`endif

// >>> sesl_event_latch.v
// event flag register: masked set, clear, set wins over clear
// assumes sources are synchronous to clk
`timescale 1ns/10ps
`include "sesl_map.vh"
module sesl_event_latch (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] set_i,
  input  wire [7:0] mask_i,
  input  wire       clear_i,
  output reg  [7:0] flags_q
);
  reg [7:0] flags_d;
  always @* begin
    flags_d = clear_i ? 8'h00 : flags_q;
    flags_d = (flags_d | (set_i & mask_i)) & `SESL_EVT_USED;
  end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= `SESL_EVT_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule // sesl_event_latch

// >>> sesl_sync2.v
// two-stage synchroniser for a bus of levels from outside the clock domain
// assumes each bit is a slow level or a stretched pulse
`timescale 1ns/10ps
module sesl_sync2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // sesl_sync2

// >>> sesl_status_core.v
// standard event register, its enable mask, status byte and service request enable
// assumes a command decoder on clk issuing cmd_op with cmd_data for one cycle per command;
// fault and status levels from other logic arrive asynchronously and are synchronised here
`timescale 1ns/10ps
`include "sesl_map.vh"
module sesl_status_core (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [2:0] cmd_op,
  input  wire [7:0] cmd_data,
  input  wire       ops_pending,
  input  wire       opc_armed_in,
  input  wire       err_queue_empty_rd,
  input  wire       read_without_cmd,
  input  wire       io_buffers_full,
  input  wire       selftest_fail,
  input  wire       calib_fail,
  input  wire       device_fault,
  input  wire       exec_error,
  input  wire       syntax_error,
  input  wire       err_queue_nonempty,
  input  wire       questionable_sum,
  input  wire       message_avail,
  output reg  [7:0] resp_data,
  output reg        resp_valid,
  output reg  [7:0] std_event_flags_q,
  output reg  [7:0] std_event_mask_q,
  output reg  [7:0] service_request_mask_q,
  output reg  [7:0] status_byte_q,
  output reg        service_req_q
);
  // bit assembly of the status byte from summaries
  function [7:0] stb_build;
    input [7:0] evt;
    input [7:0] ese;
    input [7:0] sre;
    input       eav;
    input       qsb;
    input       mav;
    reg   [7:0] b;
    begin
      b = 8'h00;
      b[`SESL_STB_EAV] = eav;
      b[`SESL_STB_QSB] = qsb;
      b[`SESL_STB_MAV] = mav;
      b[`SESL_STB_ESB] = |(evt & ese);
      b[`SESL_STB_MSS] = |(b & sre & ~(8'h01 << `SESL_STB_MSS));
      stb_build = b;
    end
  endfunction

  wire [10:0] async_in;
  wire [10:0] sync_out;
  assign async_in = {err_queue_empty_rd, read_without_cmd, io_buffers_full,
                     selftest_fail, calib_fail, device_fault, exec_error,
                     syntax_error, err_queue_nonempty, questionable_sum, message_avail};

  sesl_sync2 #(.W(11)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d_i     (async_in),
    .q_o     (sync_out)
  );

  wire s_qe_empty = sync_out[10];
  wire s_qe_nocmd = sync_out[9];
  wire s_qe_full  = sync_out[8];
  wire s_st_fail  = sync_out[7];
  wire s_cal_fail = sync_out[6];
  wire s_dev_flt  = sync_out[5];
  wire s_exe_err  = sync_out[4];
  wire s_syn_err  = sync_out[3];
  wire s_eav      = sync_out[2];
  wire s_qsb      = sync_out[1];
  wire s_mav      = sync_out[0];

  // rising edges only, so a fault held high does not re-latch right after a clear
  reg  [7:0] src_prev_q;
  wire [7:0] src_now;
  reg        opc_wait_q;
  reg        opc_wait_d;
  wire       opc_done = opc_wait_q & ~ops_pending;
  assign src_now = {1'b0, 1'b0, s_syn_err, s_exe_err,
                    s_st_fail | s_cal_fail | s_dev_flt,
                    s_qe_empty | s_qe_nocmd | s_qe_full,
                    1'b0, 1'b0};
  wire [7:0] evt_set;
  assign evt_set = (src_now & ~src_prev_q)
                 | ({7'h00, opc_done} << `SESL_BIT_OPC);

  // opc_armed_in comes from the command decoder on clk, no synchroniser needed
  always @* begin
    opc_wait_d = opc_wait_q;
    if (opc_armed_in) begin
      opc_wait_d = 1'b1;
    end else if (opc_done) begin
      opc_wait_d = 1'b0;
    end
  end

  wire evt_clear = (cmd_op == `SESL_OP_CLS) | (cmd_op == `SESL_OP_ESR_RD);
  wire [7:0] evt_flags;

  sesl_event_latch u_evt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set_i   (evt_set),
    .mask_i  (std_event_mask_q | (8'h01 << `SESL_BIT_PON)),
    .clear_i (evt_clear),
    .flags_q (evt_flags)
  );

  reg [7:0] ese_d;
  reg [7:0] sre_d;
  reg [7:0] resp_d;
  reg       resp_v_d;
  reg [7:0] stb_now;

  always @* begin
    ese_d    = std_event_mask_q;
    sre_d    = service_request_mask_q;
    resp_d   = 8'h00;
    resp_v_d = 1'b0;
    stb_now  = stb_build(evt_flags, std_event_mask_q, service_request_mask_q,
                         s_eav, s_qsb, s_mav);
    case (cmd_op)
      `SESL_OP_ESE_WR: begin
        ese_d = cmd_data;
      end
      `SESL_OP_ESE_RD: begin
        resp_d   = std_event_mask_q;
        resp_v_d = 1'b1;
      end
      `SESL_OP_ESR_RD: begin
        resp_d   = evt_flags;
        resp_v_d = 1'b1;
      end
      `SESL_OP_SRE_WR: begin
        sre_d = cmd_data;
      end
      `SESL_OP_SRE_RD: begin
        resp_d   = service_request_mask_q;
        resp_v_d = 1'b1;
      end
      `SESL_OP_STB_RD: begin
        resp_d   = stb_now;
        resp_v_d = 1'b1;
      end
      default: begin
        resp_v_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      std_event_mask_q       <= `SESL_MASK_RESET;
      service_request_mask_q <= `SESL_MASK_RESET;
      src_prev_q             <= 8'h00;
      opc_wait_q             <= 1'b0;
      resp_data              <= 8'h00;
      resp_valid             <= 1'b0;
      std_event_flags_q      <= `SESL_EVT_RESET;
      status_byte_q          <= 8'h00;
      service_req_q          <= 1'b0;
    end else begin
      std_event_mask_q       <= ese_d;
      service_request_mask_q <= sre_d;
      src_prev_q             <= src_now;
      opc_wait_q             <= opc_wait_d;
      resp_data              <= resp_d;
      resp_valid             <= resp_v_d;
      std_event_flags_q      <= evt_flags;
      status_byte_q          <= stb_now;
      service_req_q          <= stb_now[`SESL_STB_MSS];
    end
  end
endmodule // sesl_status_core

// >>> sesl_status_chk.sv
// checker on the status core ports: answers, masks, latches, summary bits
// assumes it is bound to sesl_status_core with all ports on one clk domain
`timescale 1ns/10ps
module sesl_status_chk (
  input logic       clk,
  input logic       sys_rst,
  input logic [2:0] cmd_op,
  input logic [7:0] cmd_data,
  input logic [7:0] resp_data,
  input logic       resp_valid,
  input logic [7:0] std_event_flags_q,
  input logic [7:0] std_event_mask_q,
  input logic [7:0] service_request_mask_q,
  input logic [7:0] status_byte_q,
  input logic       service_req_q
);
  logic is_q;
  assign is_q = (cmd_op == 3'h2) || (cmd_op == 3'h3) || (cmd_op == 3'h5) || (cmd_op == 3'h6);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_esr_read;
    cmd_op == 3'h3 ##1 resp_valid;
  endsequence
  sequence s_sre_read;
    cmd_op == 3'h5 ##1 resp_valid;
  endsequence
  a_resp_pulse: assert property (is_q |=> resp_valid) else $error("query not answered");
  a_resp_quiet: assert property (!is_q |=> !resp_valid) else $error("answer without query");
  a_unused_zero: assert property (!std_event_flags_q[1] && !std_event_flags_q[6])
    else $error("unused event bit set");
  // the flags port lags the latch by one cycle, so it still shows the answered value
  a_esr_return: assert property (s_esr_read |-> resp_data == std_event_flags_q)
    else $error("event query data wrong");
  a_esr_clear: assert property ((cmd_op == 3'h3 || cmd_op == 3'h7) |-> ##2 !std_event_flags_q[7])
    else $error("event bit kept after clear");
  a_ese_write: assert property (cmd_op == 3'h1 |=> std_event_mask_q == $past(cmd_data))
    else $error("event mask not replaced");
  a_sre_write: assert property (cmd_op == 3'h4 |=> service_request_mask_q == $past(cmd_data))
    else $error("request mask not loaded");
  a_sre_read: assert property (s_sre_read |-> resp_data == $past(service_request_mask_q))
    else $error("request mask query wrong");
  a_mss_bit: assert property (service_req_q == status_byte_q[6]) else $error("mss mismatch");
  a_mss_value: assert property (status_byte_q[6] == |(status_byte_q & $past(service_request_mask_q) & 8'hbf))
    else $error("master summary wrong");
  a_esb_bit: assert property (status_byte_q[5] == |(std_event_flags_q & $past(std_event_mask_q)))
    else $error("event summary wrong");
  a_flag_hold: assert property ((cmd_op != 3'h3 && cmd_op != 3'h7) |-> ##2
    ((std_event_flags_q & $past(std_event_flags_q)) == $past(std_event_flags_q)))
    else $error("event bit lost");
endmodule // sesl_status_chk
bind sesl_status_core sesl_status_chk u_chk (.clk(clk), .sys_rst(sys_rst), .cmd_op(cmd_op),
  .cmd_data(cmd_data), .resp_data(resp_data), .resp_valid(resp_valid),
  .std_event_flags_q(std_event_flags_q), .std_event_mask_q(std_event_mask_q),
  .service_request_mask_q(service_request_mask_q), .status_byte_q(status_byte_q),
  .service_req_q(service_req_q));

// >>> sesl_host_model.sv
// remote host model: issues one-cycle common commands with an operand
// assumes the caller starts from any point; commands change 1 ns after an edge
`timescale 1ns/10ps
module sesl_host_model (
  input  logic       clk,
  output logic [2:0] cmd_op,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_op = 3'h0;
    cmd_data = 8'h00;
  end
  // operand is the binary-weighted mask value for writes
  task cmd(input logic [2:0] op, input logic [7:0] d);
    @(posedge clk);
    #1 cmd_op = op;
    cmd_data = d;
    @(posedge clk);
    #1 cmd_op = 3'h0;
  endtask
endmodule // sesl_host_model

// >>> tb_standard_event_status_logic.sv
// testbench for the status core: events, masks, queries and clears
// assumes the host model drives commands and this bench drives event sources
`timescale 1ns/10ps
module tb_standard_event_status_logic;
  logic       clk, sys_rst, pend, opc, msg, eq, qs, rv, srq;
  logic [2:0] cmd_op;
  logic [7:0] cmd_data, ev, rd, flags, ese, sre, stb, ex;
  int         n_errors, checks_done, i;
  sesl_host_model u_host (.clk(clk), .cmd_op(cmd_op), .cmd_data(cmd_data));
  sesl_status_core u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .ops_pending(pend), .opc_armed_in(opc), .err_queue_empty_rd(ev[0]),
    .read_without_cmd(ev[1]), .io_buffers_full(ev[2]), .selftest_fail(ev[3]),
    .calib_fail(ev[4]), .device_fault(ev[5]), .exec_error(ev[6]), .syntax_error(ev[7]),
    .err_queue_nonempty(eq), .questionable_sum(qs), .message_avail(msg),
    .resp_data(rd), .resp_valid(rv), .std_event_flags_q(flags), .std_event_mask_q(ese),
    .service_request_mask_q(sre), .status_byte_q(stb), .service_req_q(srq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task qry(input logic [2:0] op, input logic [7:0] exp);
    u_host.cmd(op, 8'h00);
    // the answer stands only in the cycle after the taking edge
    chk({7'h00, rv}, 8'h01);
    chk(rd, exp);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task summarize;
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_reset;
    chk(flags, 8'h80);
    chk(ese, 8'h00);
    chk(sre, 8'h00);
    qry(3'h3, 8'h80);
    wait_n(1);
    chk(flags, 8'h00);
  endtask
  task t_sources;
    u_host.cmd(3'h1, 8'hff);
    for (i = 0; i < 8; i++) begin
      u_host.cmd(3'h7, 8'h00);
      ev = 8'h01 << i;
      wait_n(2);
      ev = 8'h00;
      wait_n(5);
      ex = (i < 3) ? 8'h04 : (i < 6) ? 8'h08 : (i == 6) ? 8'h10 : 8'h20;
      chk(flags, ex);
      chk(stb & 8'h20, 8'h20);
    end
    u_host.cmd(3'h7, 8'h00);
    wait_n(1);
    chk(flags, 8'h00);
  endtask
  task t_mask;
    u_host.cmd(3'h1, 8'h01);
    qry(3'h2, 8'h01);
    ev = 8'h40;
    wait_n(2);
    ev = 8'h00;
    wait_n(5);
    chk(flags, 8'h00);
    pend = 1'b1;
    opc = 1'b1;
    wait_n(1);
    opc = 1'b0;
    wait_n(4);
    chk(flags, 8'h00);
    pend = 1'b0;
    wait_n(4);
    qry(3'h3, 8'h01);
  endtask
  task t_stb;
    u_host.cmd(3'h1, 8'hff);
    u_host.cmd(3'h4, 8'hff);
    qry(3'h5, 8'hff);
    u_host.cmd(3'h4, 8'h20);
    qry(3'h5, 8'h20);
    ev = 8'h80;
    msg = 1'b1;
    wait_n(2);
    ev = 8'h00;
    wait_n(6);
    qry(3'h6, 8'h70);
    qry(3'h6, 8'h70);
    chk({7'h00, srq}, 8'h01);
    u_host.cmd(3'h7, 8'h00);
    wait_n(4);
    chk(stb, 8'h10);
    chk({7'h00, srq}, 8'h00);
    eq = 1'b1;
    qs = 1'b1;
    u_host.cmd(3'h4, 8'h08);
    wait_n(4);
    chk(stb, 8'h5c);
    chk({7'h00, srq}, 8'h01);
  endtask
  task t_rerst;
    {eq, qs, msg} = '0;
    wait_n(1);
    sys_rst = 1'b1;
    wait_n(2);
    sys_rst = 1'b0;
    chk(flags, 8'h80);
    chk(ese, 8'h00);
    chk(sre, 8'h00);
    chk(stb, 8'h00);
    chk({7'h00, srq}, 8'h00);
    qry(3'h3, 8'h80);
  endtask
  initial begin
    sys_rst = 1'b1;
    {pend, opc, msg, eq, qs, ev, n_errors, checks_done} = '0;
    wait_n(16);
    sys_rst = 1'b0;
    t_reset();
    t_sources();
    t_mask();
    t_stb();
    t_rerst();
    summarize();
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule // tb_standard_event_status_logic
